// ### include/gks_pkg.sv
// Package for the pin block with keypad scanner: register map, field positions,
// reset values, event encodings and the carrier structs shared by the design.
// Assumes one system clock; the register port is a plain address/strobe port.
package gks_pkg;

   // Register byte offsets.
   localparam logic [7:0] GKS_OFF_CTRL = 8'h00;
   localparam logic [7:0] GKS_OFF_DIR = 8'h04;
   localparam logic [7:0] GKS_OFF_OUT = 8'h08;
   localparam logic [7:0] GKS_OFF_DRVEN = 8'h0C;
   localparam logic [7:0] GKS_OFF_FUNC = 8'h10;
   localparam logic [7:0] GKS_OFF_MASK = 8'h14;
   localparam logic [7:0] GKS_OFF_PINST = 8'h18;
   localparam logic [7:0] GKS_OFF_STRAP = 8'h1C;
   localparam logic [7:0] GKS_OFF_ROWSEL = 8'h20;
   localparam logic [7:0] GKS_OFF_COLSEL = 8'h24;
   localparam logic [7:0] GKS_OFF_PRESC = 8'h28;
   localparam logic [7:0] GKS_OFF_DEB = 8'h2C;
   localparam logic [7:0] GKS_OFF_RPT = 8'h30;
   localparam logic [7:0] GKS_OFF_HOLD = 8'h34;
   localparam logic [7:0] GKS_OFF_EVENT = 8'h38;
   localparam logic [7:0] GKS_OFF_QSTAT = 8'h3C;

   // Field positions.
   localparam int unsigned GKS_CTRL_KP_EN = 0;
   localparam int unsigned GKS_CTRL_SCAN_EN = 1;
   localparam int unsigned GKS_CTRL_APPLY = 2;
   localparam int unsigned GKS_FUNC_CS = 0;
   localparam int unsigned GKS_QSTAT_OVF = 8;
   localparam int unsigned GKS_CS_PIN = 9;
   localparam int unsigned GKS_STRAP_W = 3;

   // Reset values of the timing registers: the prescaler in clock cycles, the others in prescaled ticks.
   localparam logic [15:0] GKS_PRESC_RST = 16'h61A8;
   localparam logic [15:0] GKS_DEB_RST = 16'h0014;
   localparam logic [15:0] GKS_RPT_RST = 16'h00C8;
   localparam logic [15:0] GKS_HOLD_RST = 16'h03E8;

   // Event types; type zero marks an empty queue read.
   localparam logic [3:0] GKS_EV_NONE = 4'h0;
   localparam logic [3:0] GKS_EV_PIN = 4'h1;
   localparam logic [3:0] GKS_EV_PRESS = 4'h2;
   localparam logic [3:0] GKS_EV_RELEASE = 4'h3;
   localparam logic [3:0] GKS_EV_HOLD = 4'h4;
   localparam logic [3:0] GKS_EV_REPEAT = 4'h5;

   // One queue entry.
   typedef struct packed {
      logic [15:0] ts;
      logic [3:0] etype;
      logic [3:0] row;
      logic [3:0] col;
      logic [2:0] rsvd;
      logic level;
   } gks_evt_s;

   // One register port request.
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic we;
      logic re;
   } gks_req_s;

   typedef enum logic [1:0] {K_IDLE, K_BOUNCE, K_DOWN, K_UP} gks_key_e;

endpackage

// ### src/gks_scanner.sv
// Pin block with matrix keypad scanner and host event queue.
// Assumes pins synchronous to clk_i, a master that never waits, and prescale of two or more while scanning.
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps

module gks_scanner
   import gks_pkg::*;
#(
   parameter int unsigned NPIN = 14,
   parameter int unsigned DEPTH = 8,
   parameter int unsigned AW = 3
) (
   // Clock, reset and enable.
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // Register port.
   input wire gks_req_s bus_i,
   output logic [31:0] rdata_o,
   // Pins.
   input wire logic [NPIN-1:0] pin_i,
   output logic [NPIN-1:0] pin_o,
   output logic [NPIN-1:0] pin_oe_n_o,
   output logic [NPIN-1:0] pd_en_o,
   // Serial chip select source and event line.
   input wire logic spi_cs_i,
   output logic event_o
);

   typedef struct packed {
      logic [NPIN-1:0] pin_st, dir_stg, en_stg, dir, en, out, mask, rowsel, colsel, oe_n, pd, drv, pend;
      logic func_stg, func, kp_en, scan_en, applied, strap_done, ovf, held;
      logic [GKS_STRAP_W-1:0] strap;
      logic [15:0] presc, deb, rpt, hold, pcnt, ts, kt, rt;
      logic [3:0] row;
      logic [1:0] acc_n;
      logic [7:0] acc_code, code;
      gks_key_e ks;
      logic [DEPTH-1:0][31:0] mem;
      logic [AW-1:0] wp, rp;
      logic [AW:0] cnt;
      logic [31:0] rdata;
      logic irq;
   } gks_state_s;

   gks_state_s q, d;
   logic tick, fend, push_kp, push, pop, rd_ev;
   logic [3:0] kp_type;
   logic [1:0] nacc;
   logic [7:0] ncode;
   logic [NPIN-1:0] chg, cols, clr;
   gks_evt_s ev;
   logic [31:0] head;

   // Saturating count of set bits, stopping at two.
   function automatic logic [1:0] ones2(input logic [NPIN-1:0] v);
      logic [1:0] n;
      n = 2'h0;
      for (int i = 0; i < NPIN; i++) begin
         if (v[i] && n != 2'h2) begin
            n = n + 2'h1;
         end
      end
      return n;
   endfunction

   // Index of the lowest set bit.
   function automatic logic [3:0] low_idx(input logic [NPIN-1:0] v);
      logic [3:0] r;
      r = 4'h0;
      for (int i = NPIN - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction

   assign head = q.mem[q.rp];
   assign rd_ev = bus_i.re && bus_i.addr == GKS_OFF_EVENT;

   // Next-state logic for the whole block.
   always_comb begin
      d = q;
      tick = 1'b0;
      fend = 1'b0;
      push_kp = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      kp_type = GKS_EV_NONE;
      ev = '0;
      clr = '0;
      nacc = q.acc_n;
      ncode = q.acc_code;
      cols = pin_i & q.colsel & q.oe_n & {NPIN{q.scan_en}};

      // Straps are caught on the first enabled edge after reset, pins still inputs.
      if (!q.strap_done) begin
         d.strap = pin_i[GKS_STRAP_W-1:0];
         d.strap_done = 1'b1;
      end

      // Input pins are sampled; driven pins show their driven level.
      d.pin_st = (pin_i & q.oe_n) | (q.drv & ~q.oe_n);
      chg = (pin_i ^ q.pin_st) & q.oe_n & q.mask & ~(q.rowsel | q.colsel);

      // Prescaler and timestamp.
      if (q.pcnt >= q.presc) begin
         d.pcnt = 16'h0000;
         tick = 1'b1;
      end else begin
         d.pcnt = q.pcnt + 16'h0001;
      end
      if (tick) begin
         d.ts = q.ts + 16'h0001;
         d.kt = (q.kt == 16'hFFFF) ? q.kt : q.kt + 16'h0001;
         d.rt = (q.rt == 16'hFFFF) ? q.rt : q.rt + 16'h0001;
      end

      // Row walk: each tick judges the row driven during it, then moves on.
      if (tick && q.scan_en) begin
         if (q.rowsel[q.row] && q.dir[q.row]) begin
            if (cols != '0) begin
               ncode = {q.row, low_idx(cols)};
            end
            nacc = (ones2(cols) == 2'h2 || q.acc_n + ones2(cols) >= 2'h2) ? 2'h2 : q.acc_n + ones2(cols);
         end
         if (q.row == 4'(NPIN - 1)) begin
            d.row = 4'h0;
            fend = 1'b1;
         end else begin
            d.row = q.row + 4'h1;
         end
         d.acc_n = fend ? 2'h0 : nacc;
         d.acc_code = fend ? 8'h00 : ncode;
      end

      // Key state machine, judged once per full frame.
      if (fend) begin
         unique case (q.ks)
            K_IDLE: begin
               if (nacc == 2'h1) begin
                  d.code = ncode;
                  d.kt = 16'h0000;
                  d.ks = K_BOUNCE;
               end
            end
            K_BOUNCE: begin
               if (nacc == 2'h1 && ncode == q.code) begin
                  if (q.kt >= q.deb) begin
                     push_kp = 1'b1;
                     kp_type = GKS_EV_PRESS;
                     d.ks = K_DOWN;
                     d.kt = 16'h0000;
                     d.held = 1'b0;
                  end
               end else begin
                  d.ks = K_IDLE;
               end
            end
            K_DOWN: begin
               if (nacc == 2'h1 && ncode == q.code) begin
                  if (!q.held && q.kt >= q.hold) begin
                     push_kp = 1'b1;
                     kp_type = GKS_EV_HOLD;
                     d.held = 1'b1;
                     d.rt = 16'h0000;
                  end else if (q.held && q.rt >= q.rpt) begin
                     push_kp = 1'b1;
                     kp_type = GKS_EV_REPEAT;
                     d.rt = 16'h0000;
                  end
               end else begin
                  d.ks = K_UP;
                  d.kt = 16'h0000;
               end
            end
            K_UP: begin
               if (nacc == 2'h0) begin
                  if (q.kt >= q.deb) begin
                     push_kp = 1'b1;
                     kp_type = GKS_EV_RELEASE;
                     d.ks = K_IDLE;
                  end
               end else if (nacc == 2'h1 && ncode == q.code) begin
                  d.ks = K_DOWN;
               end else begin
                  d.kt = 16'h0000;
               end
            end
         endcase
      end

      // Queue read: the head word is returned and removed.
      d.rdata = 32'h0000_0000;
      if (rd_ev && q.cnt != '0) begin
         d.rdata = head;
         d.rp = q.rp + AW'(1);
         pop = 1'b1;
      end

      // Queue write: keypad event first, else the lowest pending pin.
      ev.ts = q.ts;
      if (push_kp && q.kp_en) begin
         ev.etype = kp_type;
         ev.row = q.code[7:4];
         ev.col = q.code[3:0];
         ev.level = kp_type != GKS_EV_RELEASE;
         if (q.cnt == (AW+1)'(DEPTH)) begin
            d.ovf = 1'b1;
         end else begin
            push = 1'b1;
         end
      end else if (q.pend != '0 && q.cnt != (AW+1)'(DEPTH)) begin
         ev.etype = GKS_EV_PIN;
         ev.row = low_idx(q.pend);
         ev.level = q.pin_st[low_idx(q.pend)];
         clr[low_idx(q.pend)] = 1'b1;
         push = 1'b1;
      end
      if (push) begin
         d.mem[q.wp] = ev;
         d.wp = q.wp + AW'(1);
      end
      d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
      d.pend = (q.pend & ~clr) | chg;
      d.irq = d.cnt != '0;

      // Register writes.
      if (bus_i.we) begin
         unique case (bus_i.addr)
            GKS_OFF_CTRL: begin
               d.kp_en = bus_i.wdata[GKS_CTRL_KP_EN];
               d.scan_en = bus_i.wdata[GKS_CTRL_SCAN_EN];
               if (bus_i.wdata[GKS_CTRL_APPLY]) begin
                  d.dir = q.dir_stg;
                  d.en = q.en_stg;
                  d.func = q.func_stg;
                  d.applied = 1'b1;
               end
            end
            GKS_OFF_DIR: d.dir_stg = bus_i.wdata[NPIN-1:0];
            GKS_OFF_OUT: d.out = bus_i.wdata[NPIN-1:0];
            GKS_OFF_DRVEN: d.en_stg = bus_i.wdata[NPIN-1:0];
            GKS_OFF_FUNC: d.func_stg = bus_i.wdata[GKS_FUNC_CS];
            GKS_OFF_MASK: d.mask = bus_i.wdata[NPIN-1:0];
            GKS_OFF_ROWSEL: d.rowsel = bus_i.wdata[NPIN-1:0];
            GKS_OFF_COLSEL: d.colsel = bus_i.wdata[NPIN-1:0];
            GKS_OFF_PRESC: d.presc = bus_i.wdata[15:0];
            GKS_OFF_DEB: d.deb = bus_i.wdata[15:0];
            GKS_OFF_RPT: d.rpt = bus_i.wdata[15:0];
            GKS_OFF_HOLD: d.hold = bus_i.wdata[15:0];
            GKS_OFF_QSTAT: d.ovf = push_kp && q.kp_en && q.cnt == (AW+1)'(DEPTH); // Set wins over the clear.
            default: begin
            end
         endcase
      end

      // Register reads other than the queue.
      if (bus_i.re) begin
         unique case (bus_i.addr)
            GKS_OFF_CTRL: d.rdata = {29'h0, q.applied, q.scan_en, q.kp_en};
            GKS_OFF_DIR: d.rdata = 32'(q.dir_stg);
            GKS_OFF_OUT: d.rdata = 32'(q.out);
            GKS_OFF_DRVEN: d.rdata = 32'(q.en_stg);
            GKS_OFF_FUNC: d.rdata = 32'(q.func_stg);
            GKS_OFF_MASK: d.rdata = 32'(q.mask);
            GKS_OFF_PINST: d.rdata = 32'(q.pin_st);
            GKS_OFF_STRAP: d.rdata = 32'(q.strap);
            GKS_OFF_ROWSEL: d.rdata = 32'(q.rowsel);
            GKS_OFF_COLSEL: d.rdata = 32'(q.colsel);
            GKS_OFF_PRESC: d.rdata = 32'(q.presc);
            GKS_OFF_DEB: d.rdata = 32'(q.deb);
            GKS_OFF_RPT: d.rdata = 32'(q.rpt);
            GKS_OFF_HOLD: d.rdata = 32'(q.hold);
            GKS_OFF_EVENT: d.rdata = d.rdata;
            GKS_OFF_QSTAT: d.rdata = 32'({q.ovf, 8'(q.cnt)});
            default: d.rdata = 32'h0000_0000;
         endcase
      end

      // Pin drivers: chip select, then scanned rows, then enabled outputs.
      for (int p = 0; p < NPIN; p++) begin
         if (q.func && p == GKS_CS_PIN) begin
            d.drv[p] = spi_cs_i;
            d.oe_n[p] = 1'b0;
         end else if (q.scan_en && q.rowsel[p] && q.dir[p]) begin
            d.drv[p] = d.row == 4'(p);
            d.oe_n[p] = 1'b0;
         end else if (q.dir[p] && q.en[p]) begin
            d.drv[p] = q.out[p];
            d.oe_n[p] = 1'b0;
         end else begin
            d.drv[p] = 1'b0;
            d.oe_n[p] = 1'b1;
         end
      end
      d.pd = d.oe_n;
   end

   // State register; reset leaves every pin an input with its pull-down on.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '0;
         q.oe_n <= '1;
         q.pd <= '1;
         q.presc <= GKS_PRESC_RST;
         q.deb <= GKS_DEB_RST;
         q.rpt <= GKS_RPT_RST;
         q.hold <= GKS_HOLD_RST;
      end else if (ce_i) begin
         q <= d;
      end
   end

   assign rdata_o = q.rdata;
   assign pin_o = q.drv;
   assign pin_oe_n_o = q.oe_n;
   assign pd_en_o = q.pd;
   assign event_o = q.irq;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i || !ce_i);

   sequence s_apply;
      bus_i.we && bus_i.addr == GKS_OFF_CTRL && bus_i.wdata[GKS_CTRL_APPLY];
   endsequence

   sequence s_pop;
      rd_ev && q.cnt != '0;
   endsequence

   pins_at_reset_a: assert property (!q.applied |-> &pin_oe_n_o)
      else $error("pin driven before configuration applied");
   pull_down_a: assert property (pd_en_o == pin_oe_n_o)
      else $error("pull-down not matching drive state");
   kp_masked_a: assert property (push && ev.etype != GKS_EV_PIN |-> q.kp_en)
      else $error("keypad event queued while masked");
   press_debounce_a: assert property (push_kp && kp_type == GKS_EV_PRESS |-> q.kt >= q.deb)
      else $error("press reported before debounce interval");
   hold_time_a: assert property (push_kp && kp_type == GKS_EV_HOLD |-> q.kt >= q.hold && q.ks == K_DOWN)
      else $error("hold reported early");
   multi_ignore_a: assert property (fend && nacc == 2'h2 && q.ks == K_IDLE |=> q.ks == K_IDLE)
      else $error("multiple keys started a press");
   fifo_order_a: assert property (s_pop |=> rdata_o == $past(head))
      else $error("queue read returned wrong entry");
   apply_cfg_a: assert property (s_apply |=> q.applied && q.dir == $past(q.dir_stg))
      else $error("apply did not load staged directions");
   strap_cap_a: assert property ($rose(q.strap_done) |-> q.strap == $past(pin_i[GKS_STRAP_W-1:0]))
      else $error("strap capture mismatch");
   pin_event_a: assert property (chg != '0 |=> q.pend != '0 || q.cnt != '0)
      else $error("unmasked pin change lost");

endmodule // gks_scanner

// ### verification/gks_keypad_model.sv
// Board model beside the pin block: pull-downs, strap resistors and a keypad matrix of up to two keys.
// Assumes the design's outputs are registered, so the pin levels here settle without a loop.
`timescale 1ns/1ps

module gks_keypad_model (
   // Design side of the pins.
   input wire logic [13:0] pin_o,
   input wire logic [13:0] pin_oe_n_o,
   input wire logic [13:0] pd_en_o,
   // Strap resistors and keys set by the bench.
   input wire logic [13:0] ext_en_i,
   input wire logic [13:0] ext_val_i,
   input wire logic [1:0] key_en_i,
   input wire logic [3:0] k0_row_i,
   input wire logic [3:0] k0_col_i,
   input wire logic [3:0] k1_row_i,
   input wire logic [3:0] k1_col_i,
   // Levels seen by the design.
   output logic [13:0] pin_i
);
   logic [13:0] lvl;

   // A closed key joins a driven row to an undriven column; an open pin falls to its pull-down.
   always_comb begin
      lvl = '0;
      for (int p = 0; p < 14; p++) begin
         if (!pin_oe_n_o[p]) begin
            lvl[p] = pin_o[p];
         end else if (ext_en_i[p]) begin
            lvl[p] = ext_val_i[p];
         end else begin
            lvl[p] = pd_en_o[p] ? 1'b0 : ~pin_o[p];
         end
      end
      pin_i = lvl;
      if (key_en_i[0] && pin_oe_n_o[k0_col_i] && !pin_oe_n_o[k0_row_i]) begin
         pin_i[k0_col_i] = lvl[k0_col_i] | pin_o[k0_row_i];
      end
      if (key_en_i[1] && pin_oe_n_o[k1_col_i] && !pin_oe_n_o[k1_row_i]) begin
         pin_i[k1_col_i] = pin_i[k1_col_i] | pin_o[k1_row_i];
      end
   end
endmodule // gks_keypad_model

// ### verification/gks_scanner_test.sv
// Self-checking bench for the pin block: reset state, pin events, outputs, chip select and keypad.
// Assumes the board model on the pins and a master that changes the port right after each edge.
`timescale 1ns/1ps

module gks_scanner_test;
   import gks_pkg::*;
   logic clk_i, rst_i, spi_cs_i, event_o;
   gks_req_s bus_i;
   logic [31:0] rdata_o, ev, ev1;
   logic [13:0] pin_i, pin_o, pin_oe_n_o, pd_en_o, ext_en, ext_val;
   logic [1:0] key_en;
   logic [3:0] k0_row, k0_col, k1_row, k1_col;
   int error_cnt, tests_run;

   gks_scanner uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .bus_i(bus_i), .rdata_o(rdata_o),
      .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o), .pd_en_o(pd_en_o),
      .spi_cs_i(spi_cs_i), .event_o(event_o));

   gks_keypad_model board (.pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o), .pd_en_o(pd_en_o),
      .ext_en_i(ext_en), .ext_val_i(ext_val), .key_en_i(key_en), .k0_row_i(k0_row),
      .k0_col_i(k0_col), .k1_row_i(k1_row), .k1_col_i(k1_col), .pin_i(pin_i));

   // Clock of 40 ns period.
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   task automatic print_verdict();
      if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      bus_i.we <= 1'b1;
      bus_i.addr <= a;
      bus_i.wdata <= d;
      @(posedge clk_i);
      bus_i.we <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_i);
      bus_i.re <= 1'b1;
      bus_i.addr <= a;
      @(posedge clk_i);
      bus_i.re <= 1'b0;
      #1 d = rdata_o;
   endtask

   // Compares the low half of an event word; the column field only where it has meaning.
   task automatic chk_ev(input logic [31:0] w, input logic [3:0] ty, input logic [3:0] r, input logic [3:0] c,
         input logic lv, input logic use_col);
      logic [31:0] m;
      m = use_col ? 32'h0000FFF1 : 32'h0000FF01;
      chk(w & m, {16'h0000, ty, r, c, 3'h0, lv} & m);
   endtask

   // Waits a bounded time for the event line, then pops the queue head.
   task automatic wait_ev(output logic [31:0] w);
      int i;
      i = 0;
      while (event_o !== 1'b1 && i < 3000) begin
         @(posedge clk_i);
         #1 i++;
      end
      rd(GKS_OFF_EVENT, w);
   endtask

   task automatic quiet(input int n);
      logic bad;
      bad = 1'b0;
      repeat (n) begin
         @(posedge clk_i);
         #1;
         if (event_o !== 1'b0) bad = 1'b1;
      end
      chk({31'h0, bad}, 32'h0);
   endtask

   // Pops repeats until the release of the given key arrives.
   task automatic wait_release(input logic [3:0] r, input logic [3:0] c);
      int i;
      i = 0;
      wait_ev(ev);
      while (ev[15:12] === GKS_EV_REPEAT && i < 16) begin
         wait_ev(ev);
         i++;
      end
      chk_ev(ev, GKS_EV_RELEASE, r, c, 1'b0, 1'b1);
   endtask

   task automatic t_reset();
      logic [31:0] d;
      chk({18'h0, pin_oe_n_o}, 32'h3FFF);
      chk({18'h0, pd_en_o}, 32'h3FFF);
      rd(GKS_OFF_STRAP, d);
      chk(d, 32'h5);
      ext_en <= '0;
      rd(GKS_OFF_MASK, d);
      chk(d, 32'h0);
      rd(GKS_OFF_CTRL, d);
      chk(d & 32'h1, 32'h0);
      rd(8'h40, d);
      chk(d, 32'h0);
   endtask

   task automatic t_pins();
      logic [31:0] d;
      wr(GKS_OFF_MASK, 32'h30);
      ext_en <= 14'h0030;
      ext_val <= 14'h0020;
      repeat (3) @(posedge clk_i);
      ext_val <= 14'h0030;
      repeat (4) @(posedge clk_i);
      rd(GKS_OFF_PINST, d);
      chk(d, 32'h30);
      chk({31'h0, event_o}, 32'h1);
      rd(GKS_OFF_EVENT, d);
      chk_ev(d, GKS_EV_PIN, 4'h5, 4'h0, 1'b1, 1'b0);
      rd(GKS_OFF_EVENT, d);
      chk_ev(d, GKS_EV_PIN, 4'h4, 4'h0, 1'b1, 1'b0);
      rd(GKS_OFF_EVENT, d);
      chk(d & 32'hF000, 32'h0);
      wr(GKS_OFF_MASK, 32'h0);
      ext_en <= '0;
   endtask

   task automatic t_outputs();
      wr(GKS_OFF_DIR, 32'h280);
      wr(GKS_OFF_OUT, 32'h80);
      wr(GKS_OFF_DRVEN, 32'h0);
      wr(GKS_OFF_FUNC, 32'h1);
      wr(GKS_OFF_CTRL, 32'h4);
      repeat (2) @(posedge clk_i);
      #1;
      chk({31'h0, pin_oe_n_o[7]}, 32'h1);
      wr(GKS_OFF_DRVEN, 32'h280);
      wr(GKS_OFF_CTRL, 32'h4);
      repeat (2) @(posedge clk_i);
      #1;
      chk({30'h0, pin_oe_n_o[7], pin_o[7]}, 32'h1);
      chk({31'h0, pd_en_o[7]}, 32'h0);
      spi_cs_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
      chk({30'h0, pin_oe_n_o[9], pin_o[9]}, 32'h0);
      spi_cs_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      #1;
      chk({31'h0, pin_o[9]}, 32'h1);
   endtask

   // Rows on pins 3 and 4, columns on strap pin 0 and pin 10, short intervals.
   task automatic t_kp_setup();
      wr(GKS_OFF_FUNC, 32'h0);
      wr(GKS_OFF_ROWSEL, 32'h18);
      wr(GKS_OFF_COLSEL, 32'h401);
      wr(GKS_OFF_DIR, 32'h18);
      wr(GKS_OFF_DRVEN, 32'h18);
      wr(GKS_OFF_PRESC, 32'h2);
      wr(GKS_OFF_DEB, 32'h2);
      wr(GKS_OFF_HOLD, 32'h5);
      wr(GKS_OFF_RPT, 32'h3);
      wr(GKS_OFF_CTRL, 32'h6);
      k0_row <= 4'h4;
      k0_col <= 4'hA;
      k1_row <= 4'h3;
      k1_col <= 4'h0;
   endtask

   task automatic t_masked();
      key_en <= 2'b01;
      quiet(800);
      key_en <= 2'b00;
      quiet(800);
      wr(GKS_OFF_CTRL, 32'h3);
   endtask

   task automatic t_keypad();
      key_en <= 2'b01;
      wait_ev(ev);
      chk_ev(ev, GKS_EV_PRESS, 4'h4, 4'hA, 1'b1, 1'b1);
      wait_ev(ev1);
      chk_ev(ev1, GKS_EV_HOLD, 4'h4, 4'hA, 1'b1, 1'b1);
      chk({31'h0, ev1[31:16] > ev[31:16]}, 32'h1);
      wait_ev(ev);
      chk_ev(ev, GKS_EV_REPEAT, 4'h4, 4'hA, 1'b1, 1'b1);
      key_en <= 2'b00;
      wait_release(4'h4, 4'hA);
   endtask

   task automatic t_multi();
      key_en <= 2'b11;
      quiet(800);
      key_en <= 2'b00;
      quiet(800);
      key_en <= 2'b10;
      wait_ev(ev);
      chk_ev(ev, GKS_EV_PRESS, 4'h3, 4'h0, 1'b1, 1'b1);
      key_en <= 2'b00;
      wait_release(4'h3, 4'h0);
   endtask

   // Main sequence: straps held during reset, then the scenarios in turn.
   initial begin
      error_cnt = 0;
      tests_run = 0;
      rst_i = 1'b1;
      bus_i = '0;
      spi_cs_i = 1'b1;
      ext_en = 14'h0007;
      ext_val = 14'h0005;
      key_en = 2'b00;
      k0_row = 4'h4;
      k0_col = 4'hA;
      k1_row = 4'h3;
      k1_col = 4'h0;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
      t_reset();
      t_pins();
      t_outputs();
      t_kp_setup();
      t_masked();
      t_keypad();
      t_multi();
      print_verdict();
   end

   // Watchdog well beyond the longest bounded waits.
   initial begin
      #3ms;
      error_cnt++;
      print_verdict();
   end
endmodule // gks_scanner_test
